/* logic/pdlp_host.sv */
/*
  Host end of the parallel DAC load port: turns a user request into one
  complete select strobe with the direction line set for write or read.
  Assumes the converter sits on the pins directly and that its readback
  data is valid while select is low; inputs are synchronous to mclk.
*/

module pdlp_host
  import pdlp_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // user request
  input  wire logic       req_valid,
  input  wire pdlp_req_s  req,
  output logic            req_ready,
  // user answer
  output logic            rsp_valid,
  output pdlp_word_t      rsp_rdata,
  // converter control pins
  output logic            sel_n,
  output logic            rw,
  // converter data pins
  input  wire pdlp_word_t db_in,
  output pdlp_word_t      db_out,
  output pdlp_word_t      db_oe_n
);

  // ****************************************************************
  // state
  // ****************************************************************
  pdlp_state_e st_q;
  pdlp_state_e st_d;
  pdlp_req_s   req_q;
  pdlp_ctl_s   ctl_q;
  pdlp_ctl_s   ctl_d;
  logic        drive_q;
  logic        drive_d;
  logic        rsp_valid_q;
  pdlp_word_t  rdata_q;
  logic        ready_q;
  logic        tmr_load;
  logic [3:0]  tmr_val;
  logic        tmr_done;
  logic        take;
  logic        capture;
  logic        st_idle;
  logic        st_low;
  logic        st_rise;
  logic        st_gap;
  logic        nxt_idle;
  logic        nxt_low;
  logic        wr_done;
  pdlp_word_t  oe_n_q;

  // ****************************************************************
  // state decode
  // ****************************************************************
  assign st_idle  = (st_q == PDLP_IDLE);
  assign st_low   = (st_q == PDLP_LOW);
  assign st_rise  = (st_q == PDLP_RISE);
  assign st_gap   = (st_q == PDLP_GAP);
  assign nxt_idle = (st_d == PDLP_IDLE);
  assign nxt_low  = (st_d == PDLP_LOW);
  // a request is only taken once ready shows, never on the edge after reset
  assign take     = st_idle && req_valid && ready_q;
  assign capture  = st_low && tmr_done && req_q.rd;
  assign wr_done  = st_rise && !req_q.rd;

  // ****************************************************************
  // phase sequencing
  // ****************************************************************
  // one strobe per word
  always_comb
  begin
    st_d     = st_q;
    tmr_load = 1'b0;
    tmr_val  = PDLP_SETUP_CYC;
    unique case (st_q)
      PDLP_IDLE:
        if (take)
        begin
          st_d     = PDLP_SETUP;
          tmr_load = 1'b1;
          tmr_val  = PDLP_SETUP_CYC;
        end
      PDLP_SETUP:
        if (tmr_done)
        begin
          st_d     = PDLP_LOW;
          tmr_load = 1'b1;
          tmr_val  = PDLP_SEL_LOW_CYC;
        end
      PDLP_LOW:
        if (tmr_done)
          st_d = PDLP_RISE;
      PDLP_RISE:
      begin
        st_d     = PDLP_GAP;
        tmr_load = 1'b1;
        tmr_val  = PDLP_GAP_CYC;
      end
      PDLP_GAP:
        if (tmr_done)
          st_d = PDLP_IDLE;
      default:
        st_d = PDLP_IDLE;
    endcase
  end

  // ****************************************************************
  // pin drive
  // ****************************************************************
  // direction low and data driven for a write
  // direction high and data released for a read
  assign ctl_d   = '{sel_n: ~nxt_low, rw: (take ? req.rd : ctl_q.rw)};
  // data stays driven until after select has risen so the latch sees it
  assign drive_d = take ? ~req.rd :
                   (st_gap && tmr_done) ? 1'b0 : drive_q;

  pdlp_timer u_timer (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= PDLP_IDLE;
    else
      st_q <= st_d;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_q <= '{sel_n: 1'b1, rw: 1'b1};
    else
      ctl_q <= ctl_d;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      drive_q <= 1'b0;
    else
      drive_q <= drive_d;
  end

  // ready is registered from the next state, so it rises with idle but stays low through reset until the first edge after
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ready_q <= 1'b0;
    else
      ready_q <= nxt_idle && !take;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      req_q <= '0;
    else if (take)
      req_q <= req;
  end

  // ****************************************************************
  // readback capture
  // ****************************************************************
  // sample the readback word just before select rises
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (capture)
      rdata_q <= db_in;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rsp_valid_q <= 1'b0;
    else
      rsp_valid_q <= capture || wr_done;
  end

  // ****************************************************************
  // per-pin output enable
  // ****************************************************************
  // one flop per pin so each enable can sit beside its pad
  for (genvar b = 0; b < PDLP_WORD_W; b++)
  begin : g_oe
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        oe_n_q[b] <= 1'b1;
      else
        oe_n_q[b] <= ~drive_d;
    end
  end

  // write completes at the select rise, answered after it
  assign req_ready = ready_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_rdata = rdata_q;
  assign sel_n     = ctl_q.sel_n;
  assign rw        = ctl_q.rw;
  assign db_out    = req_q.wdata;
  // data released whenever no write is under way
  assign db_oe_n   = oe_n_q;

endmodule

/* include/pdlp_pkg.sv */
/*
  Package for the parallel DAC load port host controller: word width,
  strobe timing counts and the request / answer carriers.
  Assumes a single 20 MHz clock domain and a 12-bit converter word.
*/
package pdlp_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int unsigned PDLP_WORD_W      = 12;
  localparam int unsigned PDLP_CLK_NS      = 50;
  // strobe low time, setup before strobe and gap after it, in ns
  localparam int unsigned PDLP_SEL_LOW_NS  = 100;
  localparam int unsigned PDLP_SETUP_NS    = 50;
  localparam int unsigned PDLP_GAP_NS      = 50;
  localparam logic [3:0]  PDLP_SEL_LOW_CYC =
    4'((PDLP_SEL_LOW_NS + PDLP_CLK_NS - 1) / PDLP_CLK_NS);
  localparam logic [3:0]  PDLP_SETUP_CYC   =
    4'((PDLP_SETUP_NS + PDLP_CLK_NS - 1) / PDLP_CLK_NS);
  localparam logic [3:0]  PDLP_GAP_CYC     =
    4'((PDLP_GAP_NS + PDLP_CLK_NS - 1) / PDLP_CLK_NS);

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef logic [PDLP_WORD_W-1:0] pdlp_word_t;

  typedef struct packed {
    logic       rd;
    pdlp_word_t wdata;
  } pdlp_req_s;

  typedef struct packed {
    logic       sel_n;
    logic       rw;
  } pdlp_ctl_s;

  typedef enum logic [4:0] {
    PDLP_IDLE  = 5'h01,
    PDLP_SETUP = 5'h02,
    PDLP_LOW   = 5'h04,
    PDLP_RISE  = 5'h08,
    PDLP_GAP   = 5'h10
  } pdlp_state_e;

endpackage

/* logic/pdlp_timer.sv */
/*
  Down counter used to time the setup, select-low and gap phases of a strobe cycle.
  Assumes load and count requests come from the same clock domain.
*/
module pdlp_timer
  import pdlp_pkg::*;
(
  // clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // control
  input  wire logic       load,
  input  wire logic [3:0] load_val,
  // status
  output logic            done
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  assign cnt_d = load ? load_val : ((cnt_q != 4'h0) ? 4'(cnt_q - 4'h1) : cnt_q);
  assign done  = (cnt_q == 4'h1) || (cnt_q == 4'h0);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 4'h0;
    else
      cnt_q <= cnt_d;
  end

endmodule

/* dv/pdlp_host_chk.sv */
/* host-side strobe checks on the pins
   assumes the single mclk domain */
module pdlp_host_chk
  import pdlp_pkg::*;
(
  // clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // pins and answer
  input wire logic       sel_n,
  input wire logic       rw,
  input wire pdlp_word_t db_out,
  input wire pdlp_word_t db_oe_n,
  input wire logic       rsp_valid,
  input wire logic       req_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_sel_low_two: assert property ($fell(sel_n) |=> !sel_n ##1 sel_n)
    else $error("select low time wrong");
  a_write_drive: assert property (!sel_n && !rw |-> db_oe_n == '0 && $stable(db_out))
    else $error("write data not driven");
  a_word_hold: assert property ($rose(sel_n) && !rw |-> db_oe_n == '0 && $stable(db_out))
    else $error("word moved at select rise");
  a_read_float: assert property (!sel_n && rw |-> &db_oe_n)
    else $error("host drives during read");
  a_strobe_done: assert property ($rose(sel_n) |-> ##[0:1] rsp_valid)
    else $error("no answer after strobe");
  a_busy_strobe: assert property (!sel_n |-> !req_ready)
    else $error("ready during strobe");
  a_idle_float: assert property (sel_n && req_ready |-> &db_oe_n)
    else $error("host drives while idle");
endmodule
bind pdlp_host pdlp_host_chk chk (.mclk(mclk), .rst_n(rst_n), .sel_n(sel_n), .rw(rw),
  .db_out(db_out), .db_oe_n(db_oe_n), .rsp_valid(rsp_valid), .req_ready(req_ready));

/* dv/pdlp_dev.sv */
/* behavioural converter port
   assumes host pins straight on it */
module pdlp_dev
  import pdlp_pkg::*;
(
  // pins
  input wire logic       sel_n,
  input wire logic       rw,
  input wire pdlp_word_t db_out,
  input wire pdlp_word_t db_oe_n,
  output pdlp_word_t     db_in,
  output pdlp_word_t     dac_q
);
  timeunit 1ns;
  timeprecision 1ns;
  pdlp_word_t inp_q = '0;
  pdlp_word_t bus;
  initial dac_q = '0;
  assign bus = (db_oe_n == '0) ? db_out : ~inp_q;
  always @(posedge sel_n)
    if (rw === 1'b0)
    begin
      dac_q = bus;
      inp_q = dac_q;
    end
  always @(negedge sel_n)
    if (rw === 1'b1)
      inp_q = dac_q;
  assign db_in = (!sel_n && rw) ? inp_q : ~inp_q;
endmodule

/* dv/pdlp_host_tb.sv */
/* random writes and readbacks
   assumes the device model above */
module pdlp_host_tb;
  import pdlp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 0, rst_n = 0, req_valid = 0;
  pdlp_req_s  req = '0, e;
  logic       req_ready, rsp_valid, sel_n, rw;
  pdlp_word_t rsp_rdata, db_in, db_out, db_oe_n, dac_q, shadow;
  pdlp_req_s  exp_q[$];
  int         fail_count = 0, n_checks = 0;
  always #25 mclk = ~mclk;
  pdlp_host dut (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .sel_n(sel_n), .rw(rw), .db_in(db_in),
    .db_out(db_out), .db_oe_n(db_oe_n));
  pdlp_dev dev (.sel_n(sel_n), .rw(rw), .db_out(db_out), .db_oe_n(db_oe_n), .db_in(db_in), .dac_q(dac_q));
  task automatic check(string what, pdlp_word_t exp, pdlp_word_t got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // valid stays up so requests go back to back
  task automatic send(logic rd, pdlp_word_t w);
    int n;
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{rd: rd, wdata: w};
    for (n = 0; req_ready !== 1'b1 && n < 40; n++)
      @(negedge mclk);
    check("ready", 12'h001, {11'h000, req_ready});
    @(posedge mclk);
    exp_q.push_back('{rd: rd, wdata: rd ? shadow : w});
  endtask
  always @(negedge mclk)
    if (rsp_valid === 1'b1 && exp_q.size() == 0)
      check("spurious", 12'h000, 12'h001);
    else if (rsp_valid === 1'b1)
    begin
      e = exp_q.pop_front();
      if (e.rd)
        check("rdata", e.wdata, rsp_rdata);
      else
        check("dac", e.wdata, dac_q);
    end
  initial
  begin
    void'($urandom(88));
    shadow = '0;
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    send(1'b1, 12'h000);
    for (int i = 0; i < 8; i++)
    begin
      send(1'b0, i == 0 ? 12'hFFF : 12'($urandom));
      shadow = req.wdata;
      if (i[0])
        send(1'b1, 12'h000);
    end
    @(negedge mclk);
    req_valid = 1'b0;
    repeat (12) @(negedge mclk);
    check("pending", 12'h000, 12'(exp_q.size()));
    conclude();
  end
  // 13 requests of under 12 cycles each
  initial
  begin
    #(50 * 2000);
    fail_count++;
    conclude();
  end
endmodule
